//--- src/mpbfa_pkg.sv
package mpbfa_pkg;
  localparam int MPBFA_WORD_W = 16;
  localparam int MPBFA_BYTE_W = 8;
  localparam int MPBFA_SECT_N = 4;
  localparam int MPBFA_SECT_W = 4;
  localparam int MPBFA_DEPTH = 16;
  localparam int MPBFA_PTR_W = 4;
  localparam int MPBFA_CNT_W = 5;
  // Byte 0 is the upper lane of the word, byte 1 the lower lane
  localparam int MPBFA_BYTE0_LSB = 8;
  localparam int MPBFA_BYTE1_LSB = 0;
  localparam int MPBFA_CLK_PERIOD_NS = 100;
  localparam int MPBFA_WR_PULSE_NS = 150;
  localparam int MPBFA_WR_PULSE_CYC =
    (MPBFA_WR_PULSE_NS + MPBFA_CLK_PERIOD_NS - 1) / MPBFA_CLK_PERIOD_NS;
  localparam logic [1:0] MPBFA_PULSE_CNT_RST = 2'h0;
  localparam logic [1:0] MPBFA_PULSE_CNT_LOAD = 2'(MPBFA_WR_PULSE_CYC);
  localparam logic [15:0] MPBFA_WORD_RST = 16'h0000;
  localparam logic [7:0] MPBFA_BYTE_RST = 8'h00;
  localparam logic [3:0] MPBFA_PTR_RST = 4'h0;
  localparam logic [4:0] MPBFA_CNT_RST = 5'h00;
  localparam logic [4:0] MPBFA_CNT_FULL = 5'h10;
  localparam logic [1:0] MPBFA_SKID_CNT_RST = 2'h0;
  localparam logic [1:0] MPBFA_SKID_CNT_FULL = 2'h2;
  localparam logic [3:0] MPBFA_NIB_RST = 4'h0;
endpackage

//--- src/mpbfa_fifo_sect.sv
module mpbfa_fifo_sect
  import mpbfa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic load_strobe_input,
  input wire logic load_qualify_input,
  input wire logic unload,
  input wire logic [MPBFA_SECT_W-1:0] din,
  output logic [MPBFA_SECT_W-1:0] dout,
  output logic in_ready,
  output logic out_ready
);
  logic [MPBFA_SECT_W-1:0] mem_r [MPBFA_DEPTH];
  logic [MPBFA_PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [MPBFA_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [MPBFA_SECT_W-1:0] dout_r, dout_nxt;
  logic wr, rd;

  assign in_ready = (cnt_r != MPBFA_CNT_FULL) && !clear;
  assign out_ready = (cnt_r != MPBFA_CNT_RST) && !clear;
  assign dout = dout_r;

  always_comb
  begin
    wr = load_strobe_input && load_qualify_input && in_ready;
    rd = unload && out_ready;
    wp_nxt = wr ? wp_r + 4'h1 : wp_r;
    rp_nxt = rd ? rp_r + 4'h1 : rp_r;
    cnt_nxt = cnt_r + (wr ? 5'h01 : 5'h00) - (rd ? 5'h01 : 5'h00);
    // First word location is kept in a register; bypass a word landing there now
    dout_nxt = (wr && (wp_r == rp_nxt)) ? din : mem_r[rp_nxt];
    if (clear)
    begin
      wp_nxt = MPBFA_PTR_RST;
      rp_nxt = MPBFA_PTR_RST;
      cnt_nxt = MPBFA_CNT_RST;
      dout_nxt = MPBFA_NIB_RST;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr)
      mem_r[wp_r] <= din;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r <= MPBFA_PTR_RST;
      rp_r <= MPBFA_PTR_RST;
      cnt_r <= MPBFA_CNT_RST;
      dout_r <= MPBFA_NIB_RST;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
    end
  end
endmodule

//--- src/mpbfa_skid2.sv
module mpbfa_skid2
  import mpbfa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [MPBFA_WORD_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [MPBFA_WORD_W-1:0] out_data
);
  logic [MPBFA_WORD_W-1:0] e0_r, e0_nxt, e1_r, e1_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != MPBFA_SKID_CNT_FULL);
  assign out_valid = (cnt_r != MPBFA_SKID_CNT_RST);
  assign out_data = e0_r;

  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    e0_nxt = e0_r;
    e1_nxt = e1_r;
    cnt_nxt = cnt_r + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    if (pop)
      e0_nxt = (cnt_r == MPBFA_SKID_CNT_FULL) ? e1_r : in_data;
    if (push && (cnt_r == MPBFA_SKID_CNT_RST))
      e0_nxt = in_data;
    if (push && (cnt_r == 2'h1) && !pop)
      e1_nxt = in_data;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      e0_r <= MPBFA_WORD_RST;
      e1_r <= MPBFA_WORD_RST;
      cnt_r <= MPBFA_SKID_CNT_RST;
    end
    else
    begin
      e0_r <= e0_nxt;
      e1_r <= e1_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

//--- src/mpbfa_top.sv
// Operation
// - Output write enable is the AND of four section input-ready flags.
// - Low-true output enable is NAND of output-ready flags; inverse flags data available.
// - Each buffer write needs a high qualify input plus the capturing strobe.
// - Low write-to-input order clears input buffer and blocks its strobe; a strobe already running keeps its full two cycles.
// - Strobe captures bus data only while input write enable is high.
// - Read-direct or read-delayed selection unloads input buffer into the aligner.
// - Direct read passes both bytes in their original lanes.
// - Delayed read latches byte 1, puts byte 0 in byte-1 lane.
// - Later delayed reads output latched byte with new first byte.
// - Aligned data reach the internal bus through read-gated drivers.
// - Output buffer accepts a write only while its write enable is high.
// - Output write strobe comes from direct or delayed selection, qualified by suppress.
// - Delayed write holds data in latches until suppress releases.
// - Direct write goes straight into the output buffer.
// - Output swap exchanges upper and lower eight bits.
// - Power-up with orders low clears both buffers; order low clears only the input buffer, and reset clears the output one.
// - Writing one buffer keeps the other cleared.
// - Output buffer drivers and internal-bus inputs are always enabled.
// - One 200 ns (two-cycle) write strobe per controller data-valid assertion.
module mpbfa_top
  import mpbfa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic write_to_inbuf_order,
  input wire logic controller_data_valid,
  input wire logic [MPBFA_WORD_W-1:0] periph_bus_data,
  input wire logic read_direct_sel,
  input wire logic read_delayed_sel,
  output logic [MPBFA_WORD_W-1:0] internal_bus_rdata,
  output logic internal_bus_oe,
  input wire logic internal_bus_ready,
  output logic read_inbuf,
  output logic read_inbuf_n,
  input wire logic [MPBFA_WORD_W-1:0] internal_bus_wdata,
  input wire logic write_direct_sel,
  input wire logic write_delayed_sel,
  input wire logic suppress_outbuf_clock,
  input wire logic outbuf_unload,
  output logic [MPBFA_WORD_W-1:0] periph_out_data,
  output logic periph_out_oe,
  output logic outbuf_write_enable,
  output logic outbuf_output_enable_n,
  output logic outbuf_data_available,
  output logic outbuf_write_strobe,
  output logic inbuf_write_enable,
  output logic inbuf_write_strobe_enable,
  output logic inbuf_write_strobe,
  output logic inbuf_data_available_n
);
  logic dav_meta_r;
  logic dav_sync_r;
  logic dav_prev_r;
  logic [MPBFA_WORD_W-1:0] pin_meta_r;
  logic [MPBFA_WORD_W-1:0] pin_sync_r;
  logic [MPBFA_WORD_W-1:0] pin_hold_r;
  logic [MPBFA_WORD_W-1:0] pin_hold_nxt;

  logic [1:0] pulse_cnt_r;
  logic [1:0] pulse_cnt_nxt;
  logic pulse_first_r;
  logic pulse_first_nxt;

  logic [MPBFA_SECT_N-1:0] ib_in_rdy;
  logic [MPBFA_SECT_N-1:0] ib_out_rdy;
  logic [MPBFA_SECT_N-1:0] ob_in_rdy;
  logic [MPBFA_SECT_N-1:0] ob_out_rdy;
  logic [MPBFA_WORD_W-1:0] ib_dout;
  logic [MPBFA_WORD_W-1:0] ob_din;
  logic ib_clear;
  logic ob_clear;
  logic ib_unload;
  logic ib_out_ready_all;

  logic rd_sel;
  logic rd_take;
  logic skid_in_ready;
  logic [MPBFA_WORD_W-1:0] aligned;
  logic [MPBFA_BYTE_W-1:0] held_byte_r;
  logic [MPBFA_BYTE_W-1:0] held_byte_nxt;

  logic [MPBFA_WORD_W-1:0] swap_hold_r;
  logic [MPBFA_WORD_W-1:0] swap_hold_nxt;
  logic swap_pend_r;
  logic swap_pend_nxt;
  logic ob_strobe;

  // Pins come from another domain: two stages before any logic looks at them
  // Data ride on the valid handshake: the word has settled long before valid is seen
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dav_meta_r <= 1'b0;
      dav_sync_r <= 1'b0;
      pin_meta_r <= MPBFA_WORD_RST;
      pin_sync_r <= MPBFA_WORD_RST;
    end
    else
    begin
      dav_meta_r <= controller_data_valid;
      dav_sync_r <= dav_meta_r;
      pin_meta_r <= periph_bus_data;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign inbuf_write_strobe_enable = write_to_inbuf_order;

  always_comb
  begin
    pin_hold_nxt = pin_hold_r;
    pulse_first_nxt = 1'b0;
    pulse_cnt_nxt = (pulse_cnt_r != MPBFA_PULSE_CNT_RST) ? pulse_cnt_r - 2'h1 : pulse_cnt_r;
    if (dav_sync_r && !dav_prev_r && inbuf_write_strobe_enable)
    begin
      pulse_cnt_nxt = MPBFA_PULSE_CNT_LOAD;
      pulse_first_nxt = 1'b1;
      // Word frozen at the detected edge, so a later bus change cannot reach the write
      pin_hold_nxt = pin_sync_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dav_prev_r <= 1'b0;
      pulse_cnt_r <= MPBFA_PULSE_CNT_RST;
      pulse_first_r <= 1'b0;
      pin_hold_r <= MPBFA_WORD_RST;
    end
    else
    begin
      dav_prev_r <= dav_sync_r;
      pulse_cnt_r <= pulse_cnt_nxt;
      pulse_first_r <= pulse_first_nxt;
      pin_hold_r <= pin_hold_nxt;
    end
  end

  // Strobe keeps its full length if the order drops; the clear still blocks the write
  assign inbuf_write_strobe = (pulse_cnt_r != MPBFA_PULSE_CNT_RST);

  // orders low at power-up keep the input buffer clear; reset clears the output one
  // writing one buffer holds the other clear
  assign ib_clear = !write_to_inbuf_order;
  assign ob_clear = write_to_inbuf_order;

  // A word arriving while the input buffer is full is dropped without warning
  // enable from all four input-ready flags
  assign inbuf_write_enable = &ib_in_rdy;
  assign outbuf_write_enable = &ob_in_rdy;
  assign outbuf_output_enable_n = ~&ob_out_rdy;
  assign outbuf_data_available = !outbuf_output_enable_n;

  assign ib_out_ready_all = &ib_out_rdy;
  assign rd_sel = read_direct_sel || read_delayed_sel;
  // either selection unloads, held off while the drain buffer is full
  assign rd_take = rd_sel && ib_out_ready_all && skid_in_ready;
  // Unload and drain push are one event, so a stalled consumer loses no word
  assign ib_unload = rd_take;
  // false while a read is under way
  // Hidden so the firmware never counts a word that is already leaving
  assign inbuf_data_available_n = !(ib_out_ready_all && !rd_sel);

  genvar gi;
  generate
    for (gi = 0; gi < MPBFA_SECT_N; gi++)
    begin : g_sect
      // All sections see the same strobes, so their flags stay in step
      // strobe plus qualifying enable; refused when enable low
      mpbfa_fifo_sect u_ib (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clear(ib_clear),
        .load_strobe_input(pulse_first_r),
        .load_qualify_input(inbuf_write_enable),
        .unload(ib_unload),
        .din(pin_hold_r[gi*MPBFA_SECT_W +: MPBFA_SECT_W]),
        .dout(ib_dout[gi*MPBFA_SECT_W +: MPBFA_SECT_W]),
        .in_ready(ib_in_rdy[gi]),
        .out_ready(ib_out_rdy[gi])
      );
      // write only while output write enable high
      mpbfa_fifo_sect u_ob (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clear(ob_clear),
        .load_strobe_input(ob_strobe),
        .load_qualify_input(outbuf_write_enable),
        .unload(outbuf_unload),
        .din(ob_din[gi*MPBFA_SECT_W +: MPBFA_SECT_W]),
        .dout(periph_out_data[gi*MPBFA_SECT_W +: MPBFA_SECT_W]),
        .in_ready(ob_in_rdy[gi]),
        .out_ready(ob_out_rdy[gi])
      );
    end
  endgenerate

  // always driven
  // No other source shares these lines, so no turn-around is needed
  assign periph_out_oe = 1'b1;

  always_comb
  begin
    held_byte_nxt = held_byte_r;
    // direct keeps lanes
    // Direct wins when both selections are high
    aligned = ib_dout;
    if (read_delayed_sel && !read_direct_sel)
    begin
      // byte 0 moves to byte-1 lane
      // previous byte leads in byte-0 lane
      aligned = {held_byte_r, ib_dout[MPBFA_BYTE0_LSB +: MPBFA_BYTE_W]};
    end
    // Held byte survives direct reads, so a new delayed burst starts with a stale lane
    if (rd_take && read_delayed_sel && !read_direct_sel)
      held_byte_nxt = ib_dout[MPBFA_BYTE1_LSB +: MPBFA_BYTE_W];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      held_byte_r <= MPBFA_BYTE_RST;
    else
      held_byte_r <= held_byte_nxt;
  end

  // A stalled internal bus fills these two entries, then stops unloading
  mpbfa_skid2 u_skid (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(rd_take),
    .in_ready(skid_in_ready),
    .in_data(aligned),
    .out_valid(read_inbuf),
    .out_ready(internal_bus_ready),
    .out_data(internal_bus_rdata)
  );

  // drivers gated by the read controls
  assign read_inbuf_n = !read_inbuf;
  assign internal_bus_oe = read_inbuf;

  always_comb
  begin
    swap_hold_nxt = swap_hold_r;
    swap_pend_nxt = swap_pend_r;
    ob_strobe = 1'b0;
    ob_din = swap_hold_r;
    // A direct write while a swapped word waits goes first; the held word follows
    if (write_direct_sel)
    begin
      ob_din = internal_bus_wdata;
      ob_strobe = !suppress_outbuf_clock;
    end
    else if (write_delayed_sel)
    begin
      swap_hold_nxt = {internal_bus_wdata[MPBFA_BYTE1_LSB +: MPBFA_BYTE_W],
                       internal_bus_wdata[MPBFA_BYTE0_LSB +: MPBFA_BYTE_W]};
      ob_din = swap_hold_nxt;
      ob_strobe = !suppress_outbuf_clock;
      swap_pend_nxt = suppress_outbuf_clock;
    end
    else if (swap_pend_r && !suppress_outbuf_clock)
    begin
      // held word goes in once suppress releases
      ob_strobe = 1'b1;
      swap_pend_nxt = 1'b0;
    end
    // Entering input mode forgets a swapped word still waiting
    if (ob_clear)
      swap_pend_nxt = 1'b0;
  end

  // strobe from either selection, qualified by suppress
  assign outbuf_write_strobe = ob_strobe;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      swap_hold_r <= MPBFA_WORD_RST;
      swap_pend_r <= 1'b0;
    end
    else
    begin
      swap_hold_r <= swap_hold_nxt;
      swap_pend_r <= swap_pend_nxt;
    end
  end
endmodule

//--- dv/mpbfa_top_sva.sv
module mpbfa_top_chk
  import mpbfa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic write_to_inbuf_order,
  input wire logic controller_data_valid,
  input wire logic read_direct_sel,
  input wire logic read_delayed_sel,
  input wire logic internal_bus_oe,
  input wire logic read_inbuf,
  input wire logic read_inbuf_n,
  input wire logic write_direct_sel,
  input wire logic suppress_outbuf_clock,
  input wire logic outbuf_unload,
  input wire logic periph_out_oe,
  input wire logic outbuf_write_enable,
  input wire logic outbuf_output_enable_n,
  input wire logic outbuf_data_available,
  input wire logic outbuf_write_strobe,
  input wire logic inbuf_write_enable,
  input wire logic inbuf_write_strobe_enable,
  input wire logic inbuf_write_strobe,
  input wire logic inbuf_data_available_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence dav_rise_s;
    $rose(controller_data_valid) && write_to_inbuf_order;
  endsequence
  // Exactly two high cycles, then low
  sequence strobe_s;
    $rose(inbuf_write_strobe) ##1 inbuf_write_strobe ##1 !inbuf_write_strobe;
  endsequence
  strobe_shape_a: assert property (dav_rise_s |-> ##[1:4] strobe_s)
    else $error("input strobe missing or wrong length");
  ib_off_a: assert property (!write_to_inbuf_order |-> !inbuf_write_enable && !inbuf_write_strobe)
    else $error("input buffer writable while order low");
  strobe_en_a: assert property (inbuf_write_strobe_enable == write_to_inbuf_order)
    else $error("input strobe enable differs from order");
  avail_inv_a: assert property (outbuf_data_available != outbuf_output_enable_n)
    else $error("data available is not inverse of output enable");
  rd_gate_a: assert property (read_inbuf_n != read_inbuf && internal_bus_oe == read_inbuf)
    else $error("read drivers not gated by read control");
  drv_on_a: assert property (periph_out_oe)
    else $error("output drivers not enabled");
  rd_hide_a: assert property (read_direct_sel || read_delayed_sel |-> inbuf_data_available_n)
    else $error("input data available during read");
  sup_block_a: assert property (suppress_outbuf_clock |-> !outbuf_write_strobe)
    else $error("output strobe while suppressed");
  sequence wr_direct_s;
    write_direct_sel && !suppress_outbuf_clock && outbuf_write_enable;
  endsequence
  wr_direct_a: assert property (wr_direct_s |=> outbuf_data_available)
    else $error("direct write not in output buffer");
  sequence wr_refused_s;
    outbuf_write_strobe && !outbuf_write_enable && !outbuf_unload;
  endsequence
  wr_refuse_a: assert property (wr_refused_s |=> $stable(outbuf_data_available) && !outbuf_write_enable)
    else $error("refused write changed output buffer");
  ob_clear_a: assert property (write_to_inbuf_order [*2] |-> !outbuf_data_available && !outbuf_write_enable)
    else $error("output buffer not held clear");
endmodule

//--- dv/mpbfa_ctrl_model.sv
module mpbfa_ctrl_model
  import mpbfa_pkg::*;
(
  input wire logic ref_clk,
  output logic controller_data_valid,
  output logic [MPBFA_WORD_W-1:0] periph_bus_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    controller_data_valid = 1'b0;
    periph_bus_data = 16'hA5C3;
  end
  // Data settle before valid and turn over once released, so a stale word never looks fresh
  task automatic send(input logic [MPBFA_WORD_W-1:0] w);
    @(posedge ref_clk);
    periph_bus_data <= w;
    @(posedge ref_clk);
    controller_data_valid <= 1'b1;
    repeat (5) @(posedge ref_clk);
    controller_data_valid <= 1'b0;
    periph_bus_data <= ~w;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

//--- dv/mpbfa_top_tb.sv
module mpbfa_top_tb
  import mpbfa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_b, write_to_inbuf_order, read_direct_sel, read_delayed_sel, internal_bus_ready;
  logic write_direct_sel, write_delayed_sel, suppress_outbuf_clock, outbuf_unload, controller_data_valid;
  logic [15:0] periph_bus_data, internal_bus_wdata, internal_bus_rdata, periph_out_data, w;
  logic internal_bus_oe, read_inbuf, read_inbuf_n, periph_out_oe, outbuf_write_enable, outbuf_output_enable_n;
  logic outbuf_data_available, outbuf_write_strobe, inbuf_write_enable, inbuf_write_strobe_enable;
  logic inbuf_write_strobe, inbuf_data_available_n;
  logic [15:0] inq[$], outq[$];
  int error_cnt = 0;
  int n_checks = 0;
  mpbfa_top i_mpbfa_top (.*);
  mpbfa_ctrl_model i_mpbfa_ctrl_model (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input bit del);
    @(posedge ref_clk);
    read_direct_sel <= !del;
    read_delayed_sel <= del;
    #1;
    chk("avail during read", inbuf_data_available_n, 1);
    @(posedge ref_clk);
    read_direct_sel <= 1'b0;
    read_delayed_sel <= 1'b0;
    #1;
  endtask
  task automatic pop(input logic [15:0] exp, input logic [15:0] msk);
    for (int i = 0; i < 8 && read_inbuf !== 1'b1; i++)
      cyc(1);
    chk("read valid", read_inbuf, 1);
    chk("inbuf word", internal_bus_rdata & msk, exp & msk);
    cyc(1);
  endtask
  task automatic wr(input logic [15:0] d, input bit del);
    @(posedge ref_clk);
    if (!suppress_outbuf_clock && outq.size() < MPBFA_DEPTH)
      outq.push_back(del ? {d[7:0], d[15:8]} : d);
    internal_bus_wdata <= d;
    write_direct_sel <= !del;
    write_delayed_sel <= del;
    @(posedge ref_clk);
    write_direct_sel <= 1'b0;
    write_delayed_sel <= 1'b0;
    #1;
  endtask
  task automatic drain();
    while (outq.size() > 0)
    begin
      chk("outbuf avail", outbuf_data_available, 1);
      chk("outbuf word", periph_out_data, outq.pop_front());
      @(posedge ref_clk);
      outbuf_unload <= 1'b1;
      @(posedge ref_clk);
      outbuf_unload <= 1'b0;
      cyc(1);
    end
  endtask
  initial
  begin
    void'($urandom(32'h7C0E));
    {rst_b, write_to_inbuf_order, read_direct_sel, read_delayed_sel, write_direct_sel} = 5'h00;
    {write_delayed_sel, suppress_outbuf_clock, outbuf_unload, internal_bus_ready} = 4'h1;
    internal_bus_wdata = 16'h0000;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(1);
    chk("outbuf empty", outbuf_output_enable_n, 1);
    chk("inbuf empty", inbuf_data_available_n, 1);
    chk("outbuf we", outbuf_write_enable, 1);
    $display("test reset done");
    @(posedge ref_clk);
    write_to_inbuf_order <= 1'b1;
    cyc(2);
    chk("inbuf we", inbuf_write_enable, 1);
    chk("outbuf we", outbuf_write_enable, 0);
    for (int k = 0; k < 4; k++)
    begin
      w = 16'($urandom);
      inq.push_back(w);
      i_mpbfa_ctrl_model.send(w);
    end
    // Stall the consumer so the two-entry buffer fills and refuses further unloads
    @(posedge ref_clk);
    internal_bus_ready <= 1'b0;
    read_direct_sel <= 1'b1;
    cyc(4);
    @(posedge ref_clk);
    read_direct_sel <= 1'b0;
    internal_bus_ready <= 1'b1;
    #1;
    chk("inbuf kept", inbuf_data_available_n, 0);
    pop(inq.pop_front(), 16'hFFFF);
    pop(inq.pop_front(), 16'hFFFF);
    w = inq.pop_front();
    rd(1'b1);
    pop({8'h00, w[15:8]}, 16'h00FF);
    rd(1'b1);
    pop({w[7:0], inq[0][15:8]}, 16'hFFFF);
    chk("inbuf drained", inbuf_data_available_n, 1);
    $display("test input path done");
    i_mpbfa_ctrl_model.send(16'h1234);
    chk("inbuf avail", inbuf_data_available_n, 0);
    @(posedge ref_clk);
    write_to_inbuf_order <= 1'b0;
    cyc(2);
    chk("inbuf cleared", inbuf_data_available_n, 1);
    i_mpbfa_ctrl_model.send(16'h4321);
    chk("inbuf refused", inbuf_data_available_n, 1);
    $display("test input clear done");
    for (int k = 0; k <= MPBFA_DEPTH; k++)
      wr(16'($urandom), 1'($urandom));
    chk("outbuf full", outbuf_write_enable, 0);
    drain();
    chk("outbuf empty", outbuf_output_enable_n, 1);
    $display("test output fill done");
    @(posedge ref_clk);
    suppress_outbuf_clock <= 1'b1;
    w = 16'($urandom);
    wr(w, 1'b1);
    cyc(3);
    chk("held by suppress", outbuf_data_available, 0);
    @(posedge ref_clk);
    suppress_outbuf_clock <= 1'b0;
    outq.push_back({w[7:0], w[15:8]});
    cyc(2);
    drain();
    $display("test suppress done");
    report_and_stop();
  end
  initial
  begin
    #(2000 * MPBFA_CLK_PERIOD_NS);
    error_cnt++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
bind mpbfa_top mpbfa_top_chk i_mpbfa_top_chk (.*);
